// >>> verilog/sdram_mode_config_decoder.sv
// Mode and extended mode register decode for the memory device
//
// Operation
// RULE_01: Test bit set means nothing else stored.
// RULE_02: Restart bit triggers DLL reset, self-clears.
// RULE_03: Controller waits 200 clocks before READ.
// RULE_04: Auto precharge waits write recovery after burst.
// RULE_05: Controller programs write recovery two to eight.
// RULE_06: Exit style bit picks fast or slow.
// RULE_07: CAS latency three to seven clocks.
// RULE_08: Only whole-clock latencies are supported.
// RULE_09: Controller loads only when idle, then waits.
// RULE_10: Extended register holds until reprogrammed.
// RULE_11: Controller follows DLL enable with reset.
// RULE_12: Self refresh disables, then resets DLL.
// RULE_13: Slow clock without DLL needs precharge-all.
// RULE_14: Reduced drive bit halves output strength.
// RULE_15: Complement strobe disable makes strobe single-ended.
// RULE_16: Read strobe mirrors data strobe on x8.
// RULE_17: Output disable bit turns outputs off.
// RULE_18: Two termination bits pick 50/75/150/none.
// RULE_19: Termination pin honoured in allowed states.
// RULE_20: Controller disables termination before self refresh.
// RULE_21: Termination pin held low eight clocks.
// RULE_22: Calibration field set then cleared by controller.
// RULE_23: Additive latency zero to six clocks.
// RULE_24: Read latency sum, write latency one less.
// RULE_25: Bank bits select the target register.
// RULE_26: Value latched at the load-mode edge.
`timescale 1ns/1ps
module sdram_mode_config_decoder (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Command decode from the device front end
   input wire logic load_mode_command,
   input wire logic [1:0] bank_sel,
   input wire logic [12:0] addr,
   input wire logic self_refresh_active,
   input wire logic term_state_ok,
   input wire logic is_x8,
   input wire logic burst_write_done,
   input wire logic auto_precharge,
   // Termination control pin
   input wire logic term_ctrl_pin,
   // Decoded controls
   output logic dll_reset_pulse,
   output logic dll_enabled,
   output logic dll_locked,
   output logic dll_frozen_in_pd,
   output logic [2:0] cas_latency,
   output logic [2:0] additive_latency,
   output logic [3:0] read_latency,
   output logic [3:0] write_latency,
   output logic [3:0] write_recovery,
   output logic precharge_go,
   output logic reduced_drive,
   output logic complement_strobe_en,
   output logic read_strobe_en,
   output logic read_complement_en,
   output logic outputs_disabled,
   output logic [7:0] term_ohms,
   output logic term_active,
   output logic test_mode
);
   logic [12:0] base_q; // Stored base mode value
   logic [12:0] ext_q; // Stored extended mode value
   logic restart_q; // Self-clearing restart bit
   logic sr_q; // Previous self refresh level
   logic [7:0] lock_q; // DLL lock counter
   logic [3:0] holdoff_q; // Termination hold-off counter
   logic [3:0] wr_cnt_q; // Write recovery countdown
   logic wr_busy_q; // Recovery countdown running
   logic pin_s1_q; // Termination pin sync stage one
   logic pin_s2_q; // Termination pin sync stage two
   logic base_load; // Base register load this edge
   logic ext_load; // Extended register load this edge
   logic [3:0] wr_dec; // Decoded write recovery
   logic [2:0] cas_dec; // Decoded CAS latency
   logic [2:0] al_dec; // Decoded additive latency
   logic [7:0] term_dec; // Decoded termination value

   // Decode a three-bit latency field, reserved codes give zero
   function automatic logic [2:0] lat_dec(input logic [2:0] code, input logic [2:0] lo,
                                          input logic [2:0] hi);
      lat_dec = (code >= lo && code <= hi) ? code : 3'h0;
   endfunction : lat_dec

   assign base_load = load_mode_command && bank_sel == mode_config_pkg::SEL_BASE; // RULE_25
   assign ext_load = load_mode_command && bank_sel == mode_config_pkg::SEL_EXT; // RULE_25
   // Only integer latencies exist in the encoding
   assign cas_dec = lat_dec(base_q[mode_config_pkg::CAS_LO +: 3], mode_config_pkg::CAS_MIN,
                            mode_config_pkg::CAS_MAX); // RULE_07 RULE_08
   assign al_dec = lat_dec(ext_q[mode_config_pkg::AL_LO +: 3], 3'h0,
                           mode_config_pkg::AL_MAX); // RULE_23
   // Write recovery codes 1..7 mean 2..8 clocks
   always_comb begin
      wr_dec = {1'b0, base_q[mode_config_pkg::WR_LO +: 3]} + 4'h1; // RULE_04
      if (base_q[mode_config_pkg::WR_LO +: 3] == 3'h0) begin
         wr_dec = mode_config_pkg::WR_MIN;
      end
   end
   // Termination switch decode
   always_comb begin
      unique case ({ext_q[mode_config_pkg::TERM_HI_BIT], ext_q[mode_config_pkg::TERM_LO_BIT]})
         2'h1: term_dec = mode_config_pkg::TERM_75; // RULE_18
         2'h2: term_dec = mode_config_pkg::TERM_150; // RULE_18
         2'h3: term_dec = mode_config_pkg::TERM_50; // RULE_18
         default: term_dec = mode_config_pkg::TERM_OFF;
      endcase
   end

   // Base register store, test bit blocks all other fields
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         base_q <= mode_config_pkg::BASE_RESET;
      end else if (base_load) begin // RULE_26
         if (addr[mode_config_pkg::TEST_BIT]) begin
            base_q[mode_config_pkg::TEST_BIT] <= 1'b1; // RULE_01
         end else begin
            base_q <= addr; // RULE_01
         end
      end
   end

   // Extended register store, held until next load
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ext_q <= mode_config_pkg::EXT_RESET;
      end else if (ext_load) begin // RULE_10 RULE_26
         ext_q <= addr;
      end
   end

   // Restart bit self-clears after one cycle; self refresh exit also restarts
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         restart_q <= 1'b0;
         sr_q <= 1'b0;
      end else begin
         sr_q <= self_refresh_active;
         restart_q <= (base_load && addr[mode_config_pkg::RESTART_BIT]
                       && !addr[mode_config_pkg::TEST_BIT])
                      || (sr_q && !self_refresh_active); // RULE_02 RULE_12
      end
   end

   // DLL lock counter counts the lock time after each restart
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         lock_q <= 8'h00;
      end else if (restart_q) begin
         lock_q <= mode_config_pkg::DLL_LOCK_CNT; // RULE_03
      end else if (lock_q != 8'h00) begin
         lock_q <= lock_q - 8'h01;
      end
   end

   // Termination hold-off after an enabling extended load
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         holdoff_q <= 4'h0;
      end else if (ext_load && (addr[mode_config_pkg::TERM_HI_BIT]
                                || addr[mode_config_pkg::TERM_LO_BIT])) begin
         holdoff_q <= mode_config_pkg::TERM_HOLDOFF_CNT; // RULE_21
      end else if (holdoff_q != 4'h0) begin
         holdoff_q <= holdoff_q - 4'h1;
      end
   end

   // Termination pin synchroniser
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= term_ctrl_pin;
         pin_s2_q <= pin_s1_q;
      end
   end

   // Write recovery countdown before internal precharge
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_cnt_q <= 4'h0;
         wr_busy_q <= 1'b0;
         precharge_go <= 1'b0;
      end else begin
         precharge_go <= 1'b0;
         if (burst_write_done && auto_precharge) begin
            wr_cnt_q <= wr_dec - 4'h1; // RULE_04
            wr_busy_q <= 1'b1;
         end else if (wr_busy_q) begin
            // Pulse lands exactly the programmed count of edges after the last data
            if (wr_cnt_q == 4'h0) begin
               wr_busy_q <= 1'b0;
               precharge_go <= 1'b1; // RULE_04
            end
            wr_cnt_q <= wr_cnt_q - 4'h1;
         end
      end
   end

   // Registered decoded outputs
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dll_reset_pulse <= 1'b0;
         dll_enabled <= 1'b0;
         dll_locked <= 1'b0;
         dll_frozen_in_pd <= 1'b0;
         cas_latency <= 3'h0;
         additive_latency <= 3'h0;
         read_latency <= 4'h0;
         write_latency <= 4'h0;
         write_recovery <= 4'h0;
         reduced_drive <= 1'b0;
         complement_strobe_en <= 1'b0;
         read_strobe_en <= 1'b0;
         read_complement_en <= 1'b0;
         outputs_disabled <= 1'b0;
         term_ohms <= 8'h00;
         term_active <= 1'b0;
         test_mode <= 1'b0;
      end else begin
         dll_reset_pulse <= restart_q; // RULE_02
         dll_enabled <= !ext_q[mode_config_pkg::DLL_DIS_BIT] && !self_refresh_active; // RULE_12
         dll_locked <= (lock_q == 8'h00) && !ext_q[mode_config_pkg::DLL_DIS_BIT];
         dll_frozen_in_pd <= base_q[mode_config_pkg::PD_BIT]; // RULE_06
         cas_latency <= cas_dec; // RULE_07
         additive_latency <= al_dec; // RULE_23
         read_latency <= {1'b0, al_dec} + {1'b0, cas_dec}; // RULE_24
         write_latency <= {1'b0, al_dec} + {1'b0, cas_dec} - 4'h1; // RULE_24
         write_recovery <= wr_dec;
         reduced_drive <= ext_q[mode_config_pkg::DRIVE_BIT]; // RULE_14
         complement_strobe_en <= !ext_q[mode_config_pkg::CSTRB_BIT]
                                 && !ext_q[mode_config_pkg::OUTDIS_BIT]; // RULE_15 RULE_17
         read_strobe_en <= is_x8 && ext_q[mode_config_pkg::RSTRB_BIT]
                           && !ext_q[mode_config_pkg::OUTDIS_BIT]; // RULE_16 RULE_17
         read_complement_en <= is_x8 && ext_q[mode_config_pkg::RSTRB_BIT]
                               && !ext_q[mode_config_pkg::CSTRB_BIT]
                               && !ext_q[mode_config_pkg::OUTDIS_BIT]; // RULE_15
         outputs_disabled <= ext_q[mode_config_pkg::OUTDIS_BIT]; // RULE_17
         term_ohms <= term_dec; // RULE_18
         // Pin is ignored while the post-enable hold-off still runs
         term_active <= (term_dec != mode_config_pkg::TERM_OFF) && pin_s2_q
                        && term_state_ok && !self_refresh_active
                        && (holdoff_q == 4'h0); // RULE_19 RULE_21
         test_mode <= base_q[mode_config_pkg::TEST_BIT]; // RULE_01
      end
   end
endmodule : sdram_mode_config_decoder

// >>> verilog/mode_config_pkg.sv
// Package with field positions, encodings and timing counts of the mode configuration block
package mode_config_pkg;
   // Register widths
   localparam int REG_W = 13;
   // Bank select codes during a load-mode command
   localparam logic [1:0] SEL_BASE = 2'h0;
   localparam logic [1:0] SEL_EXT = 2'h1;
   // Base mode field positions
   localparam int CAS_LO = 4;
   localparam int TEST_BIT = 7;
   localparam int RESTART_BIT = 8;
   localparam int WR_LO = 9;
   localparam int PD_BIT = 12;
   // Extended mode field positions
   localparam int DLL_DIS_BIT = 0;
   localparam int DRIVE_BIT = 1;
   localparam int TERM_LO_BIT = 2;
   localparam int AL_LO = 3;
   localparam int TERM_HI_BIT = 6;
   localparam int CAL_LO = 7;
   localparam int CSTRB_BIT = 10;
   localparam int RSTRB_BIT = 11;
   localparam int OUTDIS_BIT = 12;
   // Reset values
   localparam logic [12:0] BASE_RESET = 13'h0000;
   localparam logic [12:0] EXT_RESET = 13'h0000;
   // Termination values in ohms, zero meaning off
   localparam logic [7:0] TERM_OFF = 8'h00;
   localparam logic [7:0] TERM_75 = 8'h4b;
   localparam logic [7:0] TERM_150 = 8'h96;
   localparam logic [7:0] TERM_50 = 8'h32;
   // Latency ranges
   localparam logic [2:0] CAS_MIN = 3'h3;
   localparam logic [2:0] CAS_MAX = 3'h7;
   localparam logic [2:0] AL_MAX = 3'h6;
   localparam logic [3:0] WR_MIN = 4'h2;
   localparam logic [3:0] WR_MAX = 4'h8;
   // DLL lock time in clocks and termination hold-off after enable
   localparam int DLL_LOCK_CLOCKS = 200;
   localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CLOCKS);
   localparam logic [3:0] TERM_HOLDOFF_CNT = 4'h8;
endpackage : mode_config_pkg

// >>> testbench/mode_config_checker.sv
// Concurrent checks on the mode configuration decoder ports
`timescale 1ns/1ps
module mode_config_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Load command pins
   input wire logic load_mode_command,
   input wire logic [1:0] bank_sel,
   input wire logic [12:0] addr,
   // Decoded outputs
   input wire logic dll_reset_pulse,
   input wire logic [2:0] cas_latency,
   input wire logic [2:0] additive_latency,
   input wire logic [3:0] read_latency,
   input wire logic [3:0] write_latency,
   input wire logic reduced_drive,
   input wire logic complement_strobe_en,
   input wire logic outputs_disabled,
   input wire logic [7:0] term_ohms,
   input wire logic term_active,
   input wire logic test_mode
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   // Loads aimed at each register
   wire logic base_ld = load_mode_command && bank_sel == 2'h0;
   wire logic ext_ld = load_mode_command && bank_sel == 2'h1;
   a_test_guard: assert property (
      base_ld && addr[7] |-> ##2 test_mode && $stable(cas_latency))
      else $error("test load changed other fields");
   a_restart_pulse: assert property (
      base_ld && addr[8] && !addr[7] |-> ##2 dll_reset_pulse ##1 !dll_reset_pulse)
      else $error("restart pulse wrong");
   a_cas_load: assert property (
      base_ld && !addr[7] && addr[6:4] > 3'h2 |-> ##2 cas_latency == $past(addr[6:4], 2))
      else $error("cas latency not stored");
   a_cas_reserved: assert property (
      base_ld && !addr[7] && addr[6:4] < 3'h3 |-> ##2 cas_latency == 3'h0)
      else $error("reserved cas code accepted");
   a_latency_sum: assert property (
      cas_latency != 3'h0 |-> read_latency == additive_latency + cas_latency
         && write_latency == read_latency - 4'h1)
      else $error("latency sum wrong");
   a_ext_fields: assert property (
      ext_ld |-> ##2 reduced_drive == $past(addr[1], 2)
         && outputs_disabled == $past(addr[12], 2))
      else $error("drive or output disable wrong");
   a_strobe_pair: assert property (
      ext_ld |-> ##2 complement_strobe_en == (!$past(addr[10], 2) && !$past(addr[12], 2)))
      else $error("complement strobe wrong");
   a_term_gate: assert property (
      (term_ohms == 8'h00) [*4] |-> !term_active)
      else $error("termination on while disabled");
   a_ext_hold: assert property (
      base_ld |-> ##2 $stable(reduced_drive) && $stable(term_ohms))
      else $error("extended value lost");
endmodule : mode_config_checker
bind sdram_mode_config_decoder mode_config_checker u_chk (.ref_clk(ref_clk), .reset(reset),
   .load_mode_command(load_mode_command), .bank_sel(bank_sel), .addr(addr),
   .dll_reset_pulse(dll_reset_pulse), .cas_latency(cas_latency),
   .additive_latency(additive_latency), .read_latency(read_latency),
   .write_latency(write_latency), .reduced_drive(reduced_drive),
   .complement_strobe_en(complement_strobe_en), .outputs_disabled(outputs_disabled),
   .term_ohms(term_ohms), .term_active(term_active), .test_mode(test_mode));

// >>> testbench/controller_model.sv
// Controller model that issues load-mode commands on request
`timescale 1ns/1ps
module controller_model (
   // Clock and bench request
   input wire logic ref_clk,
   input wire logic req,
   input wire logic [1:0] req_sel,
   input wire logic [12:0] req_val,
   // Command pins toward the device
   output logic load_mode_command = 1'b0,
   output logic [1:0] bank_sel = 2'h0,
   output logic [12:0] addr = 13'h0000
);
   // One-cycle load; between loads the bus toggles so stale values never look valid
   always @(posedge ref_clk) begin
      load_mode_command <= req;
      bank_sel <= req ? req_sel : ~bank_sel;
      // No refresh is ever issued, so the slow-clock precharge-all duty never arises
      addr <= req ? req_val : ~addr;
   end
endmodule : controller_model

// >>> testbench/testbench.sv
// Self-checking bench for the mode configuration decoder
`timescale 1ns/1ps
module testbench;
   // Bench-driven inputs
   logic ref_clk = 1'b0, reset = 1'b1, req = 1'b0, sr = 1'b0, tok = 1'b1, x8 = 1'b1;
   logic bwd = 1'b0, ap = 1'b0, pin = 1'b0, ld;
   logic [1:0] sel = 2'h0, bs;
   logic [12:0] val = 13'h0000, ad;
   // Decoded outputs
   logic rp, den, lck, frz, pg, rd, cs, rs, rc, od, ta, tm;
   logic [2:0] cl, al;
   logic [3:0] rl, wl, wr;
   logic [7:0] tohm;
   int num_errors = 0, checks = 0, cycles = 0, n, rp_seen = 0;
   // Flags polled by wait_on: 0 precharge, 1 lock, 2 restart pulse
   logic [2:0] flags;
   assign flags = {rp, lck, pg};
   always #5 ref_clk = ~ref_clk;
   // Count restart pulses away from the launching edge
   always @(negedge ref_clk) begin
      if (rp === 1'b1) rp_seen++;
   end
   controller_model ctl (.ref_clk(ref_clk), .req(req), .req_sel(sel), .req_val(val),
      .load_mode_command(ld), .bank_sel(bs), .addr(ad));
   sdram_mode_config_decoder dut (.ref_clk(ref_clk), .reset(reset), .load_mode_command(ld),
      .bank_sel(bs), .addr(ad), .self_refresh_active(sr), .term_state_ok(tok), .is_x8(x8),
      .burst_write_done(bwd), .auto_precharge(ap), .term_ctrl_pin(pin), .dll_reset_pulse(rp),
      .dll_enabled(den), .dll_locked(lck), .dll_frozen_in_pd(frz), .cas_latency(cl),
      .additive_latency(al), .read_latency(rl), .write_latency(wl), .write_recovery(wr),
      .precharge_go(pg), .reduced_drive(rd), .complement_strobe_en(cs), .read_strobe_en(rs),
      .read_complement_en(rc), .outputs_disabled(od), .term_ohms(tohm), .term_active(ta),
      .test_mode(tm));
   // Verdict and end of run
   task automatic give_verdict;
      if (num_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // Compare one value and count it
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Wait edges, then let updates settle
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : tick
   // One load through the controller model, returns once outputs are updated
   task automatic load(input logic [1:0] s, input logic [12:0] v);
      @(posedge ref_clk);
      req <= 1'b1;
      sel <= s;
      val <= v;
      @(posedge ref_clk);
      req <= 1'b0;
      tick(3);
   endtask : load
   // Count edges until a flag rises, bounded
   task automatic wait_on(input int idx, input int lim);
      n = 0;
      do begin
         tick(1);
         n++;
      end while (flags[idx] !== 1'b1 && n < lim);
   endtask : wait_on
   // Every CAS code, reserved ones decode to zero
   task automatic t_cas;
      for (int c = 0; c < 8; c++) begin
         load(2'h0, 13'(c << 4));
         chk("cas", (c > 2) ? 8'(c) : 8'h00, 8'(cl));
      end
   endtask : t_cas
   // Write recovery codes and the precharge delay after the burst
   task automatic t_wr;
      for (int w = 1; w < 8; w++) begin
         load(2'h0, 13'(w << 9) | 13'h0030);
         chk("wr", 8'(w + 1), 8'(wr));
         @(posedge ref_clk);
         bwd <= 1'b1;
         ap <= 1'b1;
         @(posedge ref_clk);
         bwd <= 1'b0;
         wait_on(0, 20);
         chk("wr delay", 8'(w + 1), 8'(n));
      end
   endtask : t_wr
   // Test bit stores nothing else; unused bank codes are ignored
   task automatic t_test;
      load(2'h0, 13'h0050);
      load(2'h0, 13'h00b0);
      chk("test", 8'h01, 8'(tm));
      chk("test cas", 8'h05, 8'(cl));
      load(2'h2, 13'h0070);
      load(2'h3, 13'h0070);
      chk("bank", 8'h05, 8'(cl));
      load(2'h0, 13'h0030);
      chk("test off", 8'h00, 8'(tm));
   endtask : t_test
   // Calibration default then cleared, DLL enable, restart and lock count
   task automatic t_dll;
      load(2'h1, 13'h0381);
      chk("dll off", 8'h00, 8'(den));
      load(2'h1, 13'h0000);
      chk("dll on", 8'h01, 8'(den));
      n = rp_seen;
      load(2'h0, 13'h0130);
      chk("restart", 8'h01, 8'(rp_seen - n));
      wait_on(1, 250);
      chk("lock", 8'(mode_config_pkg::DLL_LOCK_CLOCKS), 8'(n));
      load(2'h0, 13'h1030);
      chk("pd slow", 8'h01, 8'(frz));
      load(2'h0, 13'h0030);
      chk("pd fast", 8'h00, 8'(frz));
   endtask : t_dll
   // Extended fields over a table of settings
   task automatic t_ext;
      logic [12:0] tv [4] = '{13'h0002, 13'h0c0c, 13'h1440, 13'h0874};
      logic [12:0] v;
      foreach (tv[i]) begin
         v = tv[i];
         load(2'h1, v);
         chk("drive", 8'(v[1]), 8'(rd));
         chk("strobe pair", 8'(!v[10]), 8'(cs));
         chk("read strobe", 8'(v[11]), 8'(rs));
         chk("read pair", 8'(v[11] && !v[10]), 8'(rc));
         chk("out off", 8'(v[12]), 8'(od));
         chk("term", v[6] ? (v[2] ? 8'h32 : 8'h96) : (v[2] ? 8'h4b : 8'h00), tohm);
         chk("rl", 8'(v[5:3]) + 8'h03, 8'(rl));
         chk("wl", 8'(v[5:3]) + 8'h02, 8'(wl));
      end
      load(2'h0, 13'h0030);
      chk("ext held", 8'h32, tohm);
      @(posedge ref_clk) x8 <= 1'b0;
      load(2'h1, 13'h0800);
      chk("x4 strobe", 8'h00, 8'(rs));
   endtask : t_ext
   // Termination pin gating, then self refresh entry and exit
   task automatic t_term;
      load(2'h1, 13'h0004);
      tick(8);
      @(posedge ref_clk) pin <= 1'b1;
      tick(4);
      chk("term on", 8'h01, 8'(ta));
      @(posedge ref_clk) tok <= 1'b0;
      tick(4);
      chk("term state", 8'h00, 8'(ta));
      @(posedge ref_clk) pin <= 1'b0;
      @(posedge ref_clk) sr <= 1'b1;
      tick(4);
      chk("sr dll", 8'h00, 8'(den));
      @(posedge ref_clk) sr <= 1'b0;
      wait_on(2, 8);
      chk("sr restart", 8'h01, 8'(rp));
   endtask : t_term
   // Hang limit
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         give_verdict();
      end
   end
   // Main sequence
   initial begin
      tick(4);
      chk("reset", 8'h00, {tm, rp, pg, ta, od, cl});
      @(posedge ref_clk) reset <= 1'b0;
      tick(2);
      t_cas();
      t_wr();
      t_test();
      t_dll();
      t_ext();
      t_term();
      give_verdict();
   end
endmodule : testbench
